// File: ppc_defines.svh
// Purpose: constants of the pcm port and configuration front end
// Assumes: included by its bare name
// Notes: definitions only
`ifndef PPC_DEFINES_SVH
`define PPC_DEFINES_SVH
`define PPC_CTRL_OFFSET 8'h00
`define PPC_STATUS_OFFSET 8'h04
`define PPC_CTRL_BBM_BIT 0
`define PPC_CTRL_LONG_BIT 1
`define PPC_ST_CFG_LSB 0
`define PPC_ST_REGMODE_BIT 2
`define PPC_ST_FRAMED_BIT 3
`define PPC_ST_LIN_LSB 4
`define PPC_ST_ALAW_BIT 8
`define PPC_ST_G711_BIT 9
`define PPC_CMP_BITS 5'h08
`define PPC_SLOT_AREA 9'h020
`define PPC_BIT_CNT_MAX 9'h1FF
`define PPC_FP_LOST_BITS 9'h1FF
`define PPC_STB_CNT_MAX 5'h1F
`define PPC_ALAW_XOR 8'h55
`define PPC_MULAW_XOR 8'h7F
`endif

// File: ppc_pkg.sv
// Purpose: types shared by the pcm port front end
// Assumes: nothing
// Notes: numbers live in ppc_defines.svh
`default_nettype none
package ppc_pkg;
	typedef enum logic [1:0] {PPC_CFG_NORMAL, PPC_CFG_BACK_TO_BACK, PPC_CFG_EXTENDED} ppc_cfg_t;
	typedef struct packed {
		logic        linear;
		logic [15:0] data;
	} ppc_sample_t;
	typedef struct packed {
		logic use_a;
		logic use_b;
		logic dc;
		logic last;
	} ppc_slot_t;
	typedef struct packed {
		logic long_tail;
		logic back_to_back;
	} ppc_ctrl_t;
endpackage
`default_nettype wire

// File: ppc_port_if.sv
// Purpose: pcm data ports, framing detection and canceller configuration select
// Assumes: mclk 50 MHz, bit clock and all pins asynchronous, sampled by mclk
// Notes: channel c: 0 = A port one, 1 = B port one, 2 = A port two, 3 = B port two
// Operation
// - config pins: 00 register, 01 extended, 10 back-to-back
// - register bits pick normal, back-to-back or extended
// - two ports: ref_in/send_out and send_in/ref_out
// - frame pulse means framed, steady low strobed
// - framed: 8-bit companded or 16-bit linear samples
// - mode 00 slots 0-1, mode 01 slots 2-3
// - mode 10 slots 2-3, slots 0-1 passed through
// - mode 11 linear samples over slots 0-3
// - non-normal configuration: second slot undefined
// - strobe length 8 or 16 picks data type
// - strobe a port one rising marks frame; here each channel is timed by its own strobe and no frame mark is made
// - strobe to canceller and port mapping fixed
// - strobe lengths may be mixed across ports
// - curve pin: 0 mu-law, 1 a-law
// - coding pin: 0 sign-magnitude, 1 standard codes
// - inputs taken on falling, outputs on rising edge
`include "ppc_defines.svh"
`timescale 1ns/1ps
`default_nettype none
module ppc_port_if
	import ppc_pkg::*;
(
	input  wire logic               mclk,
	input  wire logic               reset,
	input  wire logic [7:0]         paddr,
	input  wire logic               psel,
	input  wire logic               penable,
	input  wire logic               pwrite,
	input  wire logic [31:0]        pwdata,
	output var  logic [31:0]        prdata,
	output var  logic               pready,
	output var  logic               pslverr,
	input  wire logic               config_sel_a,
	input  wire logic               config_sel_b,
	input  wire logic               curve_select_pin,
	input  wire logic               coding_style_pin,
	input  wire logic               frame_pulse_in,
	input  wire logic               tdm_bit_clock,
	input  wire logic               strobe_a_port_one,
	input  wire logic               strobe_b_port_one,
	input  wire logic               strobe_a_port_two,
	input  wire logic               strobe_b_port_two,
	input  wire logic               ref_in,
	input  wire logic               send_in,
	output var  logic               send_out,
	output var  logic               send_out_oe,
	output var  logic               ref_out,
	output var  logic               ref_out_oe,
	output var  ppc_cfg_t           cfg,
	output var  logic               register_mode,
	output var  logic               framed_mode,
	output var  logic               alaw_sel,
	output var  logic               g711_sel,
	output var  logic [3:0]         rx_valid,
	output var  ppc_sample_t [3:0]  rx_sample,
	input  wire logic [3:0][15:0]   tx_word
);
	logic [11:0]     sync_a;
	logic [11:0]     sync_b;
	logic            bclk_d;
	logic            fp_d;
	logic [3:0]      stb_d;
	ppc_ctrl_t       canceller_ctrl;
	logic [8:0]      bitcnt;
	logic            frame_ok;
	logic [8:0]      fp_low_cnt;
	logic [15:0]     rx_sh [4];
	logic [4:0]      cnt [4];
	logic [3:0]      learned_lin;
	logic [15:0]     tx_hold [4];
	logic [7:0]      dc_cap [2];
	logic [1:0][7:0] dc_out [2];
	logic [1:0]      pout;
	logic [1:0]      poe;
	ppc_slot_t       role [2];
	logic [1:0]      port_mode [2];
	logic [1:0]      mode_lin;
	logic [3:0]      fr_act;
	logic [3:0]      fr_last;
	logic [3:0]      chan_lin;
	logic [31:0]     read_word;

	function automatic logic [7:0] xlate(input logic [7:0] b, input logic al,
		input logic g7);
		// involution: same mapping turns line codes to sign-magnitude and back
		return g7 ? (b ^ (al ? `PPC_ALAW_XOR : `PPC_MULAW_XOR)) : b;
	endfunction

	function automatic logic tx_bit(input logic [15:0] w, input logic lin,
		input logic [3:0] idx, input logic al, input logic g7);
		logic [7:0] cb;
		cb = xlate(w[7:0], al, g7);
		return lin ? w[4'hF - idx] : cb[3'h7 - idx[2:0]];
	endfunction

	function automatic ppc_slot_t slot_map(input logic [1:0] mode, input logic [1:0] slot);
		ppc_slot_t r;
		r = '0;
		case (mode)
			2'h0: begin
				r.use_a = (slot == 2'h0);
				r.use_b = (slot == 2'h1);
				r.last  = 1'b1;
			end
			2'h1: begin
				r.use_a = (slot == 2'h2);
				r.use_b = (slot == 2'h3);
				r.last  = 1'b1;
			end
			2'h2: begin
				r.dc    = ~slot[1];
				r.use_a = (slot == 2'h2);
				r.use_b = (slot == 2'h3);
				r.last  = 1'b1;
			end
			2'h3: begin
				r.use_a = ~slot[1];
				r.use_b = slot[1];
				r.last  = slot[0];
			end
			default: r = '0;
		endcase
		return r;
	endfunction

	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			sync_a <= 12'h000;
			sync_b <= 12'h000;
		end else begin
			sync_a <= {send_in, ref_in, strobe_b_port_two, strobe_a_port_two,
				strobe_b_port_one, strobe_a_port_one, tdm_bit_clock, frame_pulse_in,
				coding_style_pin, curve_select_pin, config_sel_b, config_sel_a};
			sync_b <= sync_a;
		end
	end

	wire       cfg_a = sync_b[0];
	wire       cfg_b = sync_b[1];
	wire       fp    = sync_b[4];
	wire       bclk  = sync_b[5];
	wire [3:0] stb   = sync_b[9:6];
	wire [1:0] din   = sync_b[11:10];
	wire       bclk_fall = bclk_d & ~bclk;
	wire       bclk_rise = ~bclk_d & bclk;
	wire [3:0] stb_rise = stb & ~stb_d;
	wire [3:0] stb_fall = ~stb & stb_d;
	wire       in_slots = frame_ok & (bitcnt < `PPC_SLOT_AREA);
	wire       apb_access = psel & penable;
	wire       ctrl_hit = (paddr == `PPC_CTRL_OFFSET);
	wire       stat_hit = (paddr == `PPC_STATUS_OFFSET);

	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			bclk_d <= 1'b0;
			fp_d   <= 1'b0;
			stb_d  <= 4'h0;
		end else begin
			bclk_d <= bclk;
			fp_d   <= fp;
			stb_d  <= stb;
		end
	end

	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			cfg           <= PPC_CFG_NORMAL;
			register_mode <= 1'b0;
		end else begin
			register_mode <= ~cfg_a & ~cfg_b;
			case ({cfg_a, cfg_b})
				2'h1: cfg <= PPC_CFG_EXTENDED;
				2'h2: cfg <= PPC_CFG_BACK_TO_BACK;
				2'h3: cfg <= PPC_CFG_NORMAL;
				default: begin
					// both bits set is illegal; fall back to normal
					if (canceller_ctrl.back_to_back & ~canceller_ctrl.long_tail)
						cfg <= PPC_CFG_BACK_TO_BACK;
					else if (canceller_ctrl.long_tail & ~canceller_ctrl.back_to_back)
						cfg <= PPC_CFG_EXTENDED;
					else
						cfg <= PPC_CFG_NORMAL;
				end
			endcase
		end
	end

	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			alaw_sel <= 1'b0;
			g711_sel <= 1'b0;
		end else begin
			alaw_sel <= sync_b[2];
			g711_sel <= sync_b[3];
		end
	end

	// a stopped bit clock freezes the loss counter, so framed mode never falls back to strobed
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			framed_mode <= 1'b0;
			fp_low_cnt  <= 9'h000;
		end else begin
			if (fp & ~fp_d)
				framed_mode <= 1'b1;
			else if (fp_low_cnt == `PPC_FP_LOST_BITS)
				framed_mode <= 1'b0;
			if (fp)
				fp_low_cnt <= 9'h000;
			else if (bclk_fall & (fp_low_cnt != `PPC_FP_LOST_BITS))
				fp_low_cnt <= fp_low_cnt + 9'h001;
		end
	end

	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			bitcnt   <= 9'h000;
			frame_ok <= 1'b0;
		end else if (~framed_mode) begin
			frame_ok <= 1'b0;
		end else if (bclk_fall) begin
			if (~fp) begin
				bitcnt   <= 9'h000;
				frame_ok <= 1'b1;
			end else if (bitcnt != `PPC_BIT_CNT_MAX) begin
				bitcnt <= bitcnt + 9'h001;
			end
		end
	end

	always_comb begin
		for (int p = 0; p < 2; p++) begin
			port_mode[p] = {stb[2*p+1], stb[2*p]};
			mode_lin[p]  = &port_mode[p];
			role[p]      = slot_map(port_mode[p], bitcnt[4:3]);
		end
		for (int c = 0; c < 4; c++) begin
			fr_act[c]   = in_slots & (c[0] ? role[c/2].use_b : role[c/2].use_a);
			fr_last[c]  = fr_act[c] & role[c/2].last & (bitcnt[2:0] == 3'h7);
			chan_lin[c] = framed_mode ? mode_lin[c/2] : learned_lin[c];
		end
	end

	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			rx_valid    <= 4'h0;
			rx_sample   <= '0;
			learned_lin <= 4'h0;
			for (int c = 0; c < 4; c++) begin
				rx_sh[c] <= 16'h0000;
				cnt[c]   <= 5'h00;
			end
		end else begin
			rx_valid <= 4'h0;
			for (int c = 0; c < 4; c++) begin
				if (framed_mode) begin
					if (bclk_fall & fp & fr_act[c])
						rx_sh[c] <= {rx_sh[c][14:0], din[c/2]};
					if (bclk_fall & fp & fr_last[c]) begin
						rx_valid[c]         <= 1'b1;
						rx_sample[c].linear <= mode_lin[c/2];
						rx_sample[c].data   <= mode_lin[c/2] ? {rx_sh[c][14:0], din[c/2]} :
							{8'h00, xlate({rx_sh[c][6:0], din[c/2]}, alaw_sel, g711_sel)};
					end
				end else begin
					if (stb_rise[c])
						cnt[c] <= 5'h00;
					else if (bclk_fall & stb[c] & (cnt[c] != `PPC_STB_CNT_MAX)) begin
						rx_sh[c] <= {rx_sh[c][14:0], din[c/2]};
						cnt[c]   <= cnt[c] + 5'h01;
					end
					if (stb_fall[c]) begin
						rx_valid[c]         <= 1'b1;
						learned_lin[c]      <= cnt[c] > `PPC_CMP_BITS;
						rx_sample[c].linear <= cnt[c] > `PPC_CMP_BITS;
						rx_sample[c].data   <= (cnt[c] > `PPC_CMP_BITS) ? rx_sh[c] :
							{8'h00, xlate(rx_sh[c][7:0], alaw_sel, g711_sel)};
					end
				end
			end
		end
	end

	// transmit words are latched so a mid-slot change cannot tear a sample
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			for (int c = 0; c < 4; c++)
				tx_hold[c] <= 16'h0000;
		end else begin
			for (int c = 0; c < 4; c++) begin
				if (framed_mode ? (bclk_fall & ~fp) : stb_rise[c])
					tx_hold[c] <= tx_word[c];
			end
		end
	end

	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			for (int p = 0; p < 2; p++) begin
				dc_cap[p] <= 8'h00;
				dc_out[p] <= 16'h0000;
			end
		end else begin
			for (int p = 0; p < 2; p++) begin
				if (framed_mode & bclk_fall & fp & in_slots & role[p].dc) begin
					dc_cap[p] <= {dc_cap[p][6:0], din[p]};
					if (bitcnt[2:0] == 3'h7)
						dc_out[p][bitcnt[3]] <= {dc_cap[p][6:0], din[p]};
				end
			end
		end
	end

	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			pout <= 2'h0;
			poe  <= 2'h0;
		end else begin
			for (int p = 0; p < 2; p++) begin
				if (framed_mode) begin
					if (bclk_rise) begin
						poe[p]  <= in_slots & (role[p].dc | role[p].use_a | role[p].use_b);
						if (role[p].dc)
							pout[p] <= dc_out[p][bitcnt[3]][3'h7 - bitcnt[2:0]];
						else if (role[p].use_b & (cfg != PPC_CFG_NORMAL))
							pout[p] <= 1'b0;
						else
							pout[p] <= tx_bit(tx_hold[2*p+(role[p].use_b ? 1 : 0)],
								mode_lin[p], {bitcnt[3], bitcnt[2:0]}, alaw_sel, g711_sel);
					end
				end else if (stb_rise[2*p] | stb_rise[2*p+1]) begin
					poe[p]  <= 1'b1;
					pout[p] <= tx_bit(tx_word[stb_rise[2*p] ? 2*p : 2*p+1],
						learned_lin[stb_rise[2*p] ? 2*p : 2*p+1], 4'h0, alaw_sel, g711_sel);
				end else if (~stb[2*p] & ~stb[2*p+1]) begin
					poe[p]  <= 1'b0;
					pout[p] <= 1'b0;
				end else if (bclk_rise) begin
					pout[p] <= tx_bit(tx_hold[stb[2*p] ? 2*p : 2*p+1],
						learned_lin[stb[2*p] ? 2*p : 2*p+1],
						cnt[stb[2*p] ? 2*p : 2*p+1][3:0], alaw_sel, g711_sel);
				end
			end
		end
	end

	assign send_out    = pout[0];
	assign send_out_oe = poe[0];
	assign ref_out     = pout[1];
	assign ref_out_oe  = poe[1];

	always_comb begin
		read_word = 32'h00000000;
		if (ctrl_hit) begin
			read_word[`PPC_CTRL_BBM_BIT]  = canceller_ctrl.back_to_back;
			read_word[`PPC_CTRL_LONG_BIT] = canceller_ctrl.long_tail;
		end else if (stat_hit) begin
			read_word[`PPC_ST_CFG_LSB +: 2]  = cfg;
			read_word[`PPC_ST_REGMODE_BIT]   = register_mode;
			read_word[`PPC_ST_FRAMED_BIT]    = framed_mode;
			read_word[`PPC_ST_LIN_LSB +: 4]  = chan_lin;
			read_word[`PPC_ST_ALAW_BIT]      = alaw_sel;
			read_word[`PPC_ST_G711_BIT]      = g711_sel;
		end
	end

	// one wait state keeps pready and prdata registered
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			pready         <= 1'b0;
			pslverr        <= 1'b0;
			prdata         <= 32'h00000000;
			canceller_ctrl <= '0;
		end else begin
			pready  <= apb_access & ~pready;
			pslverr <= apb_access & ~pready & ~(ctrl_hit | (stat_hit & ~pwrite));
			if (apb_access & ~pready)
				prdata <= pwrite ? 32'h00000000 : read_word;
			if (apb_access & pready & pwrite & ctrl_hit) begin
				canceller_ctrl.back_to_back <= pwdata[`PPC_CTRL_BBM_BIT];
				canceller_ctrl.long_tail    <= pwdata[`PPC_CTRL_LONG_BIT];
			end
		end
	end

	default clocking dc_cb @(posedge mclk);
	endclocking
	default disable iff (reset);

	property p_pin_cfg;
		(cfg_a & ~cfg_b) ##1 (cfg_a & ~cfg_b) |=> cfg == PPC_CFG_BACK_TO_BACK;
	endproperty
	a_pin_cfg: assert property (p_pin_cfg) else $error("pin config wrong");
	property p_reg_cfg;
		(register_mode & ~cfg_a & ~cfg_b & canceller_ctrl.long_tail
			& ~canceller_ctrl.back_to_back) |=> cfg == PPC_CFG_EXTENDED;
	endproperty
	a_reg_cfg: assert property (p_reg_cfg) else $error("register config wrong");
	property p_framed;
		(fp & ~fp_d) |=> framed_mode;
	endproperty
	a_framed: assert property (p_framed) else $error("frame pulse missed");
	property p_align;
		(framed_mode & bclk_fall & ~fp) |=> (bitcnt == 9'h000) && frame_ok;
	endproperty
	a_align: assert property (p_align) else $error("slot count not aligned");
	property p_mode1;
		(fr_last[1] & (port_mode[0] == 2'h0)) |-> bitcnt[4:0] == 5'h0F;
	endproperty
	a_mode1: assert property (p_mode1) else $error("mode 1 slot wrong");
	property p_mode4;
		(fr_last[0] & mode_lin[0]) |-> bitcnt[4:0] == 5'h0F;
	endproperty
	a_mode4: assert property (p_mode4) else $error("linear slot wrong");
	property p_undef;
		(framed_mode & bclk_rise & in_slots & role[0].use_b
			& (cfg != PPC_CFG_NORMAL)) |=> ~send_out;
	endproperty
	a_undef: assert property (p_undef) else $error("second slot not blanked");
	property p_len;
		(~framed_mode & stb_fall[3] & (cnt[3] == 5'h08)) |=> rx_valid[3] & ~rx_sample[3].linear;
	endproperty
	a_len: assert property (p_len) else $error("strobe length misread");
	property p_out_edge;
		(~framed_mode & send_out_oe & $past(send_out_oe) & ~$past(bclk_rise)
			& ~$past(stb_rise[0]) & ~$past(stb_rise[1])) |-> $stable(send_out);
	endproperty
	a_out_edge: assert property (p_out_edge) else $error("output moved off edge");
	property p_apb;
		(apb_access & ~pready) |=> pready ##1 ~pready;
	endproperty
	a_apb: assert property (p_apb) else $error("apb answer late");

	c_framed: cover property (framed_mode & fr_last[3]);
	c_lin: cover property (~framed_mode & rx_valid[2] & rx_sample[2].linear);
	c_dc: cover property (framed_mode & role[0].dc & bclk_rise & send_out_oe);
	c_mixed: cover property (learned_lin[2] & ~learned_lin[0]);
endmodule
`default_nettype wire

// File: ppc_link_model.sv
// Purpose: far-side pcm bus model for strobed and framed traffic
// Assumes: bit clock period 160 ns, standing low outside bursts
// Notes: device outputs lag bclk by mclk sync, so they are sampled late in the bit
`timescale 1ns/1ps
`default_nettype none
module ppc_link_model (
	output var  logic       bclk,
	output var  logic       fp_n,
	output var  logic [3:0] stb,
	output var  logic       rin,
	output var  logic       sin,
	input  wire logic       sout,
	input  wire logic       rout
);
	initial begin
		bclk = 1'b0;
		fp_n = 1'b0;
		stb  = 4'h0;
		rin  = 1'b0;
		sin  = 1'b1;
	end
	// while framed the strobe pins only pick the slot mode
	task automatic set_mode(input logic [3:0] m);
		stb = m;
	endtask
	// exactly n clocks in the window, data changes on rise
	task automatic burst(input int ch, input int n, input logic [15:0] din,
		output logic [15:0] dout);
		dout = 16'h0000;
		stb[ch] = 1'b1;
		for (int i = 0; i < n; i++) begin
			bclk = 1'b1;
			if (ch < 2)
				rin = din[n-1-i];
			else
				sin = din[n-1-i];
			#80 bclk = 1'b0;
			#79 dout = {dout[14:0], (ch < 2) ? sout : rout};
			#1;
		end
		bclk = 1'b1;
		stb[ch] = 1'b0;
		// released lines show the inverse, never a held value
		rin = ~rin;
		sin = ~sin;
		#80 bclk = 1'b0;
		#80;
	endtask
	// pulse low over one fall, then slots 0-3 msb first
	task automatic frame(input logic [31:0] din, output logic [31:0] dout);
		dout = 32'h0;
		bclk = 1'b1;
		fp_n = 1'b0;
		#80 bclk = 1'b0;
		#80;
		for (int i = 0; i < 40; i++) begin
			bclk = 1'b1;
			fp_n = 1'b1;
			rin = (i < 32) ? din[31-i] : ~rin;
			#80 bclk = 1'b0;
			#79;
			if (i < 32)
				dout = {dout[30:0], sout};
			#1;
		end
	endtask
endmodule
`default_nettype wire

// File: test_ppc_port_if.sv
// Purpose: self-checking bench of the pcm port front end
// Assumes: mclk 50 MHz, link model drives all pcm pins
// Notes: rx pulses are latched by a monitor, then compared
`include "ppc_defines.svh"
`timescale 1ns/1ps
`default_nettype none
module test_ppc_port_if
	import ppc_pkg::*;
;
	logic               mclk, reset, psel, penable, pwrite, pready, pslverr;
	logic [7:0]         paddr;
	logic [31:0]        pwdata, prdata, rdv;
	logic               cfg_a, cfg_b, curve, coding, errv;
	logic               bclk, fp_n, rin, sin, sout, sout_oe, rout, rout_oe;
	logic [3:0]         stb, rx_valid;
	ppc_cfg_t           cfg;
	logic               register_mode, framed_mode, alaw_sel, g711_sel;
	ppc_sample_t [3:0]  rx_sample;
	logic [3:0][15:0]   tx_word;
	logic [15:0]        dv;
	logic [31:0]        fv;
	ppc_sample_t        got [4];
	int                 num_errors = 0;
	int                 cmp_count = 0;
	int                 cyc = 0;
	ppc_cfg_t           pin_tab [4] = '{PPC_CFG_NORMAL, PPC_CFG_EXTENDED,
		PPC_CFG_BACK_TO_BACK, PPC_CFG_NORMAL};
	ppc_cfg_t           reg_tab [3] = '{PPC_CFG_NORMAL, PPC_CFG_BACK_TO_BACK, PPC_CFG_EXTENDED};
	// curve pin, standard code in, sign-magnitude out
	logic [16:0]        law_tab [6] = '{{1'b0, 8'hFF, 8'h80}, {1'b1, 8'hAA, 8'hFF},
		{1'b0, 8'h7F, 8'h00}, {1'b1, 8'hD5, 8'h80}, {1'b0, 8'h80, 8'hFF}, {1'b1, 8'h55, 8'h00}};

	ppc_port_if ppc_port_if_inst (.mclk(mclk), .reset(reset), .paddr(paddr), .psel(psel),
		.penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .config_sel_a(cfg_a), .config_sel_b(cfg_b),
		.curve_select_pin(curve), .coding_style_pin(coding), .frame_pulse_in(fp_n),
		.tdm_bit_clock(bclk), .strobe_a_port_one(stb[0]), .strobe_b_port_one(stb[1]),
		.strobe_a_port_two(stb[2]), .strobe_b_port_two(stb[3]), .ref_in(rin),
		.send_in(sin), .send_out(sout), .send_out_oe(sout_oe), .ref_out(rout),
		.ref_out_oe(rout_oe), .cfg(cfg), .register_mode(register_mode),
		.framed_mode(framed_mode), .alaw_sel(alaw_sel), .g711_sel(g711_sel),
		.rx_valid(rx_valid), .rx_sample(rx_sample), .tx_word(tx_word));
	ppc_link_model ppc_link_model_inst (.bclk(bclk), .fp_n(fp_n), .stb(stb), .rin(rin),
		.sin(sin), .sout(sout), .rout(rout));

	initial begin
		mclk = 1'b0;
		forever #10 mclk = ~mclk;
	end
	always @(posedge mclk) begin
		for (int c = 0; c < 4; c++) begin
			if (rx_valid[c] === 1'b1)
				got[c] <= rx_sample[c];
		end
	end
	task automatic results();
		$display("mismatches %0d of %0d compares", num_errors, cmp_count);
		if (num_errors == 0 && cmp_count > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	// ceiling well above the few thousand cycles the sequence needs
	always @(posedge mclk) begin
		cyc <= cyc + 1;
		if (cyc == 50000) begin
			num_errors++;
			results();
		end
	end
	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			num_errors++;
			$display("unexpected %s expected %h seen %h", name, exp, seen);
		end
	endtask
	// waits for pready as long as it takes; only the cycle ceiling ends a hang
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge mclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge mclk);
		penable <= 1'b1;
		do begin
			@(posedge mclk);
		end while (pready !== 1'b1);
		rdv = prdata;
		errv = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	initial begin
		reset = 1'b1;
		{psel, penable, pwrite, paddr, pwdata} = '0;
		{cfg_a, cfg_b, curve, coding} = 4'hC;
		tx_word = {16'h0055, 16'h1234, 16'h0066, 16'h00C3};
		repeat (2) @(posedge mclk);
		check("reset", {cfg, register_mode, framed_mode}, 0);
		reset <= 1'b0;
		for (int i = 0; i < 4; i++) begin
			@(posedge mclk);
			{cfg_a, cfg_b} <= i[1:0];
			repeat (8) @(posedge mclk);
			check("cfg", cfg, pin_tab[i]);
			check("register_mode", register_mode, i == 0);
		end
		// register bits only steer the configuration while both pins are low
		@(posedge mclk);
		{cfg_a, cfg_b} <= 2'b00;
		repeat (8) @(posedge mclk);
		for (int i = 0; i < 3; i++) begin
			apb(1'b1, `PPC_CTRL_OFFSET, i);
			apb(1'b0, `PPC_STATUS_OFFSET, 0);
			check("status", rdv, 32'h4 | reg_tab[i]);
			check("cfg", cfg, reg_tab[i]);
		end
		apb(1'b0, `PPC_CTRL_OFFSET, 0);
		check("ctrl", rdv, 2);
		apb(1'b0, 8'h08, 0);
		check("unmapped", {errv, rdv[30:0]}, 32'h80000000);
		apb(1'b1, `PPC_STATUS_OFFSET, 32'hFFFFFFFF);
		check("status_wr", errv, 1);
		check("cfg", cfg, PPC_CFG_EXTENDED);
		@(posedge mclk);
		{cfg_a, cfg_b} <= 2'b11;
		repeat (8) @(posedge mclk);
		for (int f = 0; f < 2; f++) begin
			ppc_link_model_inst.burst(0, 8, 16'h00A5 + f, dv);
			check("send_out", dv[7:0], 8'hC3);
			check("send_out_oe", sout_oe, 0);
			check("rx0", {got[0].linear, got[0].data[7:0]}, 8'hA5 + f);
			ppc_link_model_inst.burst(2, 16, 16'hF120 + f, dv);
			check("rx2", {got[2].linear, got[2].data}, 17'h1F120 + f);
			if (f == 1)
				check("ref_out", dv, 16'h1234);
			ppc_link_model_inst.burst(3, 8, 16'h003C + f, dv);
			check("rx3", {got[3].linear, got[3].data[7:0]}, 8'h3C + f);
			check("ref_out", dv[7:0], 8'h55);
			check("ref_out_oe", rout_oe, 0);
		end
		apb(1'b0, `PPC_STATUS_OFFSET, 0);
		check("status", rdv, 32'h40);
		for (int i = 0; i < 6; i++) begin
			@(posedge mclk);
			coding <= 1'b1;
			curve <= law_tab[i][16];
			repeat (6) @(posedge mclk);
			check("alaw_sel", alaw_sel, law_tab[i][16]);
			check("g711_sel", g711_sel, 1);
			ppc_link_model_inst.burst(0, 8, 16'h0000, dv);
			ppc_link_model_inst.burst(1, 8, {8'h00, law_tab[i][15:8]}, dv);
			check("rx1", {got[1].linear, got[1].data[7:0]}, law_tab[i][7:0]);
		end
		for (int k = 0; k < 4; k++) begin
			@(posedge mclk);
			{curve, coding} <= 2'b00;
			{cfg_a, cfg_b} <= (k < 2) ? 2'b11 : 2'b10;
			ppc_link_model_inst.frame({8'h5A + 8'(k), 8'h30 + 8'(k), 16'h0000}, fv);
			if (k == 1) begin
				check("framed_mode", framed_mode, 1);
				check("rx0", {got[0].linear, got[0].data[7:0]}, 8'h5B);
				check("rx1", {got[1].linear, got[1].data[7:0]}, 8'h31);
				check("send_out", fv[31:16], 16'hC366);
			end
			if (k == 3) begin
				check("rx0", {got[0].linear, got[0].data[7:0]}, 8'h5D);
				check("send_out", fv[23:16], 8'h00);
			end
		end
		// back-to-back stays on: modes 01, 10, 10, 11 on port one
		for (int k = 0; k < 4; k++) begin
			ppc_link_model_inst.set_mode((k == 0) ? 4'h1 : (k == 3) ? 4'h3 : 4'h2);
			// linear words skip the curve translation, so they need no a-law shift
			ppc_link_model_inst.frame((k == 3) ? 32'h1357E468 :
				{8'hD0 + 8'(k), 8'hC0 + 8'(k), 8'h70 + 8'(k), 8'h80 + 8'(k)}, fv);
			if (k < 3) begin
				check("rx0", {got[0].linear, got[0].data[7:0]}, 8'h70 + k);
				check("rx1", {got[1].linear, got[1].data[7:0]}, 8'h80 + k);
				check("send_out", fv[15:0], 16'hC300);
			end
			if (k == 2)
				check("send_out", fv[31:16], 16'hD1C1);
			if (k == 3) begin
				check("rx0", {got[0].linear, got[0].data}, 17'h11357);
				check("rx1", {got[1].linear, got[1].data}, 17'h1E468);
				check("send_out", fv, 32'h00C30000);
			end
		end
		results();
	end
endmodule
`default_nettype wire
